// file: inc/timer_pkg.sv
// constants, types and state layout for the dual timer/counter unit
package timer_pkg;

  // ==========================================================
  // register offsets (8-bit I/O space)
  localparam logic [7:0] OFS_CTL0 = 8'h33;
  localparam logic [7:0] OFS_CNT0 = 8'h32;
  localparam logic [7:0] OFS_CTL1A = 8'h2F;
  localparam logic [7:0] OFS_CTL1B = 8'h2E;
  localparam logic [7:0] OFS_CNT1_H = 8'h2D;
  localparam logic [7:0] OFS_CNT1_L = 8'h2C;
  localparam logic [7:0] OFS_OCRA_H = 8'h2B;
  localparam logic [7:0] OFS_OCRA_L = 8'h2A;
  localparam logic [7:0] OFS_OCRB_H = 8'h29;
  localparam logic [7:0] OFS_OCRB_L = 8'h28;
  localparam logic [7:0] OFS_ICR_H = 8'h25;
  localparam logic [7:0] OFS_ICR_L = 8'h24;
  localparam logic [7:0] OFS_FLAGS = 8'h38;
  localparam logic [7:0] OFS_MASK = 8'h39;
  localparam logic [7:0] OFS_ACMP = 8'h08;

  // ==========================================================
  // field positions
  localparam int FLG_OVF1 = 7;
  localparam int FLG_CMPA = 6;
  localparam int FLG_CMPB = 5;
  localparam int FLG_CAPT = 3;
  localparam int FLG_OVF0 = 1;
  localparam int ACMP_SEL_BIT = 2;
  localparam int IRQ_W = 5;

  // ==========================================================
  // clock select, compare action and pwm codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_CK = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;
  localparam logic [1:0] PWM_OFF = 2'h0;
  localparam logic [1:0] PWM_8 = 2'h1;
  localparam logic [1:0] PWM_9 = 2'h2;
  localparam logic [15:0] TOP_8 = 16'h00FF;
  localparam logic [15:0] TOP_9 = 16'h01FF;
  localparam logic [15:0] TOP_10 = 16'h03FF;
  localparam int NOISE_SAMPLES = 4;

  typedef enum logic {DIR_UP = 1'b0, DIR_DOWN = 1'b1} dir_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic [9:0] pre;
    logic t0_s, t0_d, t1_s, t1_d;
    logic [NOISE_SAMPLES-1:0] hist;
    logic filt, filt_d;
    logic [2:0] cs0;
    logic [7:0] cnt0;
    logic [1:0] coma, comb, pwm;
    logic ncl, ces, ctc;
    logic [2:0] cs1;
    logic [15:0] cnt1, ocra, ocrb, pwma, pwmb, icr;
    logic [7:0] temp, flags, mask;
    logic acsel;
    dir_e dir;
    logic counted1, oca, ocb;
    logic [7:0] rdata;
    logic [IRQ_W-1:0] irq;
  } timer_state_s;

endpackage

// file: rtl/dual_timer_counter_unit.sv
// dual timer/counter unit: shared prescaler, 8-bit and 16-bit counters
// Functional notes
// - one shared 10-bit prescaler, four taps
// - counter0 clock select decode, eight codes
// - pin edges count even as port output
// - external clock sampled on each rising mclk edge
// - counter0 counts up, writable, resumes next cycle
// - counter0 control bits 7..3 read zero
// - counter0 overflow flag with mask bit
// - counter1 overflow, compare, capture flags masked
// - counter1 compared against A and B
// - optional clear on A, pin actions
// - 8/9/10-bit centred glitch-free pwm
// - capture copies counter1 on selected event
// - comparator select replaces capture pin
// - noise filter needs four equal samples
// - timer or external event counter
// - edge select zero falling, one rising
// - clear-on-match zeroes counter1 next cycle
// - high byte staged, low byte commits
`timescale 1ns/1ps

module dual_timer_counter_unit
  import timer_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // register port
  input wire reg_req_s bus_req,
  output logic [7:0] read_data,
  // pins
  input wire logic counter0_ext_clock_pin,
  input wire logic counter1_ext_clock_pin,
  input wire logic capture_input_pin,
  input wire logic comparator_output,
  input wire logic cpu_irq_enable,
  // outputs
  output logic compare_a_out,
  output logic compare_b_out,
  output logic [IRQ_W-1:0] irq_req
);

  // ==========================================================
  // decode helpers
  function automatic logic tick_sel(input logic [2:0] cs, input logic [9:0] pre,
                                    input logic fall, input logic rise);
    logic t;
    t = 1'b0;
    unique case (cs)
      CS_STOP: t = 1'b0;
      CS_CK: t = 1'b1;
      CS_DIV8: t = &pre[2:0];
      CS_DIV64: t = &pre[5:0];
      CS_DIV256: t = &pre[7:0];
      CS_DIV1024: t = &pre[9:0];
      CS_EXT_FALL: t = fall;
      CS_EXT_RISE: t = rise;
    endcase
    return t;
  endfunction

  function automatic logic oc_next(input logic [1:0] com, input logic pwm, input dir_e dir,
                                   input logic evt, input logic cur);
    logic r;
    r = cur;
    if (evt && pwm && com[1]) begin
      r = (dir == DIR_UP) ? com[0] : ~com[0];
    end else if (evt && !pwm) begin
      case (com)
        COM_TOGGLE: r = ~cur;
        COM_CLEAR: r = 1'b0;
        COM_SET: r = 1'b1;
        default: r = cur;
      endcase
    end
    return r;
  endfunction

  timer_state_s s, n;
  logic t0_fall, t0_rise, t1_fall, t1_rise, tick0, tick1;
  logic pwm_on, wr_cnt0, wr_cnt1, evt_a, evt_b, cap_src, cap_evt;
  logic [15:0] top;
  logic [7:0] fm;

  // ==========================================================
  // combinational decode
  assign t0_fall = s.t0_d & ~s.t0_s;
  assign t0_rise = ~s.t0_d & s.t0_s;
  assign t1_fall = s.t1_d & ~s.t1_s;
  assign t1_rise = ~s.t1_d & s.t1_s;
  assign tick0 = tick_sel(s.cs0, s.pre, t0_fall, t0_rise);
  assign tick1 = tick_sel(s.cs1, s.pre, t1_fall, t1_rise);
  assign pwm_on = s.pwm != PWM_OFF;
  assign top = (s.pwm == PWM_8) ? TOP_8 : (s.pwm == PWM_9) ? TOP_9 : TOP_10;
  assign wr_cnt0 = bus_req.wr && bus_req.addr == OFS_CNT0;
  assign wr_cnt1 = bus_req.wr && bus_req.addr == OFS_CNT1_L;
  // a match only counts when the counter stepped onto the value
  assign evt_a = s.counted1 && s.cnt1 == (pwm_on ? s.pwma : s.ocra);
  assign evt_b = s.counted1 && s.cnt1 == (pwm_on ? s.pwmb : s.ocrb);
  assign cap_src = s.acsel ? comparator_output : capture_input_pin;
  assign cap_evt = (s.filt != s.filt_d) && (s.filt == s.ces);

  // ==========================================================
  // next state
  always_comb begin
    logic [7:0] set;
    logic [7:0] clr;
    set = 8'h00;
    clr = 8'h00;
    n = s;
    n.pre = s.pre + 10'h001;
    n.t0_s = counter0_ext_clock_pin;
    n.t0_d = s.t0_s;
    n.t1_s = counter1_ext_clock_pin;
    n.t1_d = s.t1_s;
    n.hist = {s.hist[NOISE_SAMPLES-2:0], cap_src};
    n.filt_d = s.filt;
    if (!s.ncl) begin
      n.filt = s.hist[0];
    end else if (&s.hist) begin
      n.filt = 1'b1;
    end else if (~|s.hist) begin
      n.filt = 1'b0;
    end
    // counter0
    if (wr_cnt0) begin
      n.cnt0 = bus_req.wdata;
    end else if (tick0) begin
      n.cnt0 = s.cnt0 + 8'h01;
      if (s.cnt0 == 8'hFF) begin
        set[FLG_OVF0] = 1'b1;
      end
    end
    // counter1
    n.counted1 = tick1 && !wr_cnt1;
    if (!pwm_on) begin
      n.dir = DIR_UP;
    end
    if (wr_cnt1) begin
      n.cnt1 = {s.temp, bus_req.wdata};
    end else if (evt_a && s.ctc && !pwm_on) begin
      n.cnt1 = 16'h0000;
    end else if (tick1 && !pwm_on) begin
      n.cnt1 = s.cnt1 + 16'h0001;
      if (&s.cnt1) begin
        set[FLG_OVF1] = 1'b1;
      end
    end else if (tick1) begin
      if (s.dir == DIR_UP && s.cnt1 < top) begin
        n.cnt1 = s.cnt1 + 16'h0001;
      end else if (s.dir == DIR_UP) begin
        // compare values reload only at the turn, so pulses never glitch
        n.dir = DIR_DOWN;
        n.cnt1 = s.cnt1 - 16'h0001;
        n.pwma = s.ocra;
        n.pwmb = s.ocrb;
      end else if (s.cnt1 != 16'h0000) begin
        n.cnt1 = s.cnt1 - 16'h0001;
      end else begin
        n.dir = DIR_UP;
        n.cnt1 = s.cnt1 + 16'h0001;
        set[FLG_OVF1] = 1'b1;
      end
    end
    if (evt_a) begin
      set[FLG_CMPA] = 1'b1;
    end
    if (evt_b) begin
      set[FLG_CMPB] = 1'b1;
    end
    n.oca = oc_next(s.coma, pwm_on, s.dir, evt_a, s.oca);
    n.ocb = oc_next(s.comb, pwm_on, s.dir, evt_b, s.ocb);
    if (cap_evt) begin
      n.icr = s.cnt1;
      set[FLG_CAPT] = 1'b1;
    end
    // register writes
    if (bus_req.wr) begin
      case (bus_req.addr)
        OFS_CTL0: n.cs0 = bus_req.wdata[2:0];
        OFS_CTL1A: begin
          n.coma = bus_req.wdata[7:6];
          n.comb = bus_req.wdata[5:4];
          n.pwm = bus_req.wdata[1:0];
        end
        OFS_CTL1B: begin
          n.ncl = bus_req.wdata[7];
          n.ces = bus_req.wdata[6];
          n.ctc = bus_req.wdata[3];
          n.cs1 = bus_req.wdata[2:0];
        end
        OFS_CNT1_H, OFS_OCRA_H, OFS_OCRB_H: n.temp = bus_req.wdata;
        OFS_OCRA_L: n.ocra = {s.temp, bus_req.wdata};
        OFS_OCRB_L: n.ocrb = {s.temp, bus_req.wdata};
        OFS_FLAGS: clr = bus_req.wdata;
        OFS_MASK: n.mask = bus_req.wdata;
        OFS_ACMP: n.acsel = bus_req.wdata[ACMP_SEL_BIT];
        default: ;
      endcase
    end
    // register reads
    n.rdata = 8'h00;
    if (bus_req.rd) begin
      case (bus_req.addr)
        OFS_CTL0: n.rdata = {5'h00, s.cs0};
        OFS_CNT0: n.rdata = s.cnt0;
        OFS_CTL1A: n.rdata = {s.coma, s.comb, 2'h0, s.pwm};
        OFS_CTL1B: n.rdata = {s.ncl, s.ces, 2'h0, s.ctc, s.cs1};
        OFS_CNT1_L: begin
          n.rdata = s.cnt1[7:0];
          n.temp = s.cnt1[15:8];
        end
        OFS_ICR_L: begin
          n.rdata = s.icr[7:0];
          n.temp = s.icr[15:8];
        end
        OFS_CNT1_H, OFS_ICR_H: n.rdata = s.temp;
        OFS_OCRA_H: n.rdata = s.ocra[15:8];
        OFS_OCRA_L: n.rdata = s.ocra[7:0];
        OFS_OCRB_H: n.rdata = s.ocrb[15:8];
        OFS_OCRB_L: n.rdata = s.ocrb[7:0];
        OFS_FLAGS: n.rdata = s.flags;
        OFS_MASK: n.rdata = s.mask;
        OFS_ACMP: n.rdata = {5'h00, s.acsel, 2'h0};
        default: n.rdata = 8'h00;
      endcase
    end
    // a hardware set in the clearing cycle survives
    n.flags = (s.flags & ~clr) | set;
    fm = n.flags & n.mask;
    n.irq = {fm[FLG_CAPT], fm[FLG_CMPB], fm[FLG_CMPA], fm[FLG_OVF1], fm[FLG_OVF0]}
            & {IRQ_W{cpu_irq_enable}};
  end

  // ==========================================================
  // state register
  always_ff @(posedge mclk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign read_data = s.rdata;
  assign compare_a_out = s.oca;
  assign compare_b_out = s.ocb;
  assign irq_req = s.irq;

  // ==========================================================
  // checks
  stop_hold_a: assert property (@(posedge mclk) disable iff (reset)
    (s.cs0 == CS_STOP && !wr_cnt0) |=> s.cnt0 == $past(s.cnt0))
    else $error("stopped counter0 moved");
  div8_rate_a: assert property (@(posedge mclk) disable iff (reset)
    (s.cs0 == CS_DIV8 && !wr_cnt0 && s.pre[2:0] != 3'h7) |=> $stable(s.cnt0))
    else $error("divide by 8 stepped early");
  ext_rise_a: assert property (@(posedge mclk) disable iff (reset)
    (s.cs0 == CS_EXT_RISE && !wr_cnt0 && !s.t0_d && s.t0_s)
    |=> s.cnt0 == $past(s.cnt0) + 8'h01)
    else $error("external rising edge not counted");
  cnt0_load_a: assert property (@(posedge mclk) disable iff (reset)
    wr_cnt0 |=> s.cnt0 == $past(bus_req.wdata))
    else $error("counter0 write lost");
  ctl0_read_a: assert property (@(posedge mclk) disable iff (reset)
    (bus_req.rd && bus_req.addr == OFS_CTL0) |=> s.rdata[7:3] == 5'h00)
    else $error("reserved control bits nonzero");
  ovf0_flag_a: assert property (@(posedge mclk) disable iff (reset)
    (tick0 && !wr_cnt0 && s.cnt0 == 8'hFF) |=> s.flags[FLG_OVF0])
    else $error("overflow flag missed");
  ctc_clear_a: assert property (@(posedge mclk) disable iff (reset)
    (evt_a && s.ctc && !pwm_on && !wr_cnt1) |=> s.cnt1 == 16'h0000 ##1 s.flags[FLG_CMPA])
    else $error("clear on match failed");
  capture_copy_a: assert property (@(posedge mclk) disable iff (reset)
    cap_evt |=> s.icr == $past(s.cnt1) && s.flags[FLG_CAPT])
    else $error("capture not taken");
  noise_filter_a: assert property (@(posedge mclk) disable iff (reset)
    (cap_evt && s.ncl && $past(s.ncl)) |-> $past(s.hist) == {NOISE_SAMPLES{s.ces}})
    else $error("capture without four samples");
  irq_gate_a: assert property (@(posedge mclk) disable iff (reset)
    |irq_req |-> $past(cpu_irq_enable) && |(s.flags & s.mask))
    else $error("request without enable");

endmodule

// file: testbench/dual_timer_counter_unit_tb.sv
// self-checking bench for the dual timer/counter unit
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end

module dual_timer_counter_unit_tb;
  import timer_pkg::*;
  logic mclk, reset, cpu_irq_enable, ca, cb, t0, t1, cap, cmp;
  reg_req_s bus_req;
  logic [7:0] read_data, r, r2, v;
  logic [IRQ_W-1:0] irq_req;
  logic [15:0] w;
  int seed, n_errors, tests_run, k, n, c;

  dual_timer_counter_unit dut_u (.mclk(mclk), .reset(reset), .bus_req(bus_req), .read_data(read_data),
    .counter0_ext_clock_pin(t0), .counter1_ext_clock_pin(t1), .capture_input_pin(cap),
    .comparator_output(cmp), .cpu_irq_enable(cpu_irq_enable), .compare_a_out(ca),
    .compare_b_out(cb), .irq_req(irq_req));
  timer_pin_model pm_u (.mclk(mclk), .counter0_ext_clock_pin(t0), .counter1_ext_clock_pin(t1),
    .capture_input_pin(cap), .comparator_output(cmp));

  // ==========================================
  // bus tasks and helpers
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    #1 d = read_data;
  endtask

  function automatic int taps(input int s);
    return 1 << (s == 1 ? 0 : s == 2 ? 3 : s == 3 ? 6 : s == 4 ? 8 : 10);
  endfunction

  task automatic give_verdict;
    if (n_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================
  // clock and watchdog
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial begin
    repeat (100000) @(posedge mclk);
    n_errors++;
    give_verdict();
  end

  // ==========================================
  // scenarios
  initial begin
    seed = 81;
    n_errors = 0;
    tests_run = 0;
    bus_req = '0;
    cpu_irq_enable = 1'b0;
    reset = 1'b1;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    rd(OFS_CTL0, r); `CHK(r, 8'h00)
    wr(OFS_CTL0, 8'hFF);
    rd(OFS_CTL0, r); `CHK(r, 8'h07)
    rd(8'h00, r); `CHK(r, 8'h00)
    for (k = 1; k < 6; k++) begin
      wr(OFS_CTL0, {5'h00, CS_STOP});
      wr(OFS_CNT0, 8'h00);
      wr(OFS_CTL0, k[7:0]);
      repeat (4 * taps(k)) @(posedge mclk);
      wr(OFS_CTL0, {5'h00, CS_STOP});
      rd(OFS_CNT0, r); `CHK(r >= 3 && r <= 6, 1'b1)
      repeat (9) @(posedge mclk);
      rd(OFS_CNT0, r2); `CHK(r2, r)
    end
    cpu_irq_enable <= 1'b1;
    for (k = 6; k < 8; k++) begin
      wr(OFS_MASK, k == 7 ? 8'h02 : 8'h00);
      wr(OFS_FLAGS, 8'hFF);
      v = (k == 6) ? 8'hFE : 8'($random(seed));
      n = 1 + ($random(seed) & 7);
      wr(OFS_CTL0, k[7:0]);
      wr(OFS_CNT0, v);
      pm_u.pulse(0, n);
      rd(OFS_CNT0, r); `CHK(r, v + n[7:0])
      rd(OFS_FLAGS, r); `CHK(r[FLG_OVF0], v + n > 255)
      `CHK(irq_req[0], (v + n > 255) && k == 7)
    end
    cpu_irq_enable <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 `CHK(irq_req[0], 1'b0)
    wr(OFS_CTL1B, 8'h07);
    w = 16'($random(seed)) & 16'h7FFF;
    wr(OFS_CNT1_H, w[15:8]);
    wr(OFS_CNT1_L, w[7:0]);
    pm_u.pulse(1, 3);
    rd(OFS_CNT1_L, r);
    rd(OFS_CNT1_H, r2); `CHK({r2, r}, w + 16'h0003)
    wr(OFS_MASK, 8'h08);
    cpu_irq_enable <= 1'b1;
    for (k = 0; k < 4; k++) begin
      wr(OFS_ACMP, (k[0] ^ k[1]) ? 8'h04 : 8'h00);
      wr(OFS_CTL1B, {k[1], k[0], 6'h07});
      pm_u.trig(k[0] ^ k[1], ~k[0], 8);
      rd(OFS_FLAGS, r); `CHK(r[FLG_CAPT], 1'b0)
      pm_u.trig(k[0] ^ k[1], k[0], 2);
      pm_u.trig(k[0] ^ k[1], ~k[0], 8);
      rd(OFS_FLAGS, r); `CHK(r[FLG_CAPT], ~k[1])
      wr(OFS_FLAGS, 8'hFF);
      w = 16'($random(seed));
      wr(OFS_CNT1_H, w[15:8]);
      wr(OFS_CNT1_L, w[7:0]);
      pm_u.trig(k[0] ^ k[1], k[0], 10);
      rd(OFS_FLAGS, r); `CHK(r[FLG_CAPT], 1'b1)
      `CHK(irq_req[4], 1'b1)
      rd(OFS_ICR_L, r);
      rd(OFS_ICR_H, r2); `CHK({r2, r}, w)
      wr(OFS_FLAGS, 8'hFF);
    end
    c = 8'h20 + ($random(seed) & 8'h3F);
    wr(OFS_CTL1B, 8'h00);
    wr(OFS_OCRA_H, 8'h00);
    wr(OFS_OCRA_L, c[7:0]);
    wr(OFS_OCRB_H, 8'h00);
    wr(OFS_OCRB_L, c[8:1]);
    wr(OFS_CTL1A, 8'hE0);
    wr(OFS_CNT1_H, 8'h00);
    wr(OFS_CNT1_L, 8'h00);
    wr(OFS_FLAGS, 8'hFF);
    wr(OFS_CTL1B, 8'h09);
    n = 0;
    repeat (2 * c) begin
      rd(OFS_CNT1_L, r);
      if (r > n) n = r;
    end
    `CHK(n <= c && n >= c - 2, 1'b1)
    rd(OFS_FLAGS, r); `CHK(r & 8'hE0, 8'h60)
    `CHK({ca, cb}, 2'b10)
    wr(OFS_OCRA_L, 8'h80);
    wr(OFS_CTL1A, 8'h81);
    repeat (1100) @(posedge mclk);
    n = 0;
    repeat (510) begin
      @(posedge mclk);
      n += ca;
    end
    `CHK(n >= 250 && n <= 262, 1'b1)
    give_verdict();
  end
endmodule

// file: testbench/timer_pin_model.sv
// pin-side model: external clock, capture and comparator lines
`timescale 1ns/1ps

module timer_pin_model (
  // clock
  input wire logic mclk,
  // lines toward the unit
  output logic counter0_ext_clock_pin,
  output logic counter1_ext_clock_pin,
  output logic capture_input_pin,
  output logic comparator_output
);
  // ==========================================
  // line drivers
  initial begin
    counter0_ext_clock_pin = 1'b0;
    counter1_ext_clock_pin = 1'b0;
    capture_input_pin = 1'b0;
    comparator_output = 1'b0;
  end

  // n full periods; each level held two clocks so no transition is lost
  task automatic pulse(input int sel, input int n);
    repeat (2 * n) begin
      @(posedge mclk);
      if (sel == 0) counter0_ext_clock_pin <= ~counter0_ext_clock_pin;
      else counter1_ext_clock_pin <= ~counter1_ext_clock_pin;
      @(posedge mclk);
    end
    repeat (4) @(posedge mclk);
  endtask

  // drive the capture pin or the comparator line to a level and hold it
  task automatic trig(input logic src, input logic lvl, input int hold);
    @(posedge mclk);
    if (src) comparator_output <= lvl;
    else capture_input_pin <= lvl;
    repeat (hold) @(posedge mclk);
  endtask
endmodule
